// >>> wpc_ch2_checker.sv
/* Assertions on the channel 2 protection block ports.
   Assumes one clock and binding onto wpc_wire_protect_ch2. */
`timescale 1ns/100ps
`default_nettype none
module wpc_ch2_checker
	import wpc_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic [7:0]  regAddr,
	input wire logic        regWrStrobe,
	input wire logic [15:0] regWrData,
	input wire logic        regRdStrobe,
	input wire logic [15:0] regRdData,
	input wire logic        regHit,
	input wire logic        channelRequest,
	input wire logic        channelEnable,
	input wire logic        wireTrip,
	input wire logic        delayTrip,
	input wire logic        coolActive,
	input wire logic        latchedOff
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Register storage and decode
	AST_READBACK: assert property (regWrStrobe && regHit ##1 !regWrStrobe
		##1 regRdStrobe && regHit && !regWrStrobe
		|=> regRdData == ($past(regWrData, 3) & CFG_WR_MASK)) else $error("bad readback");
	AST_UNMAPPED: assert property (regRdStrobe && !regHit |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	// Shutdown and cool-down sequencing
	AST_LATCH: assert property (latchedOff |-> !channelEnable && !coolActive)
		else $error("latched but driving");
	AST_REFUSE: assert property (latchedOff && channelRequest |=> !channelEnable)
		else $error("latched retry");
	AST_COOL: assert property ($rose(coolActive) |-> !channelEnable && (wireTrip || delayTrip))
		else $error("cool without shutdown");
	AST_DELAY: assert property ($rose(delayTrip) |-> !channelEnable && !wireTrip)
		else $error("delay trip still on");
	AST_WIRE: assert property ($rose(wireTrip) |-> !channelEnable && !delayTrip)
		else $error("energy trip still on");
endmodule : wpc_ch2_checker
bind wpc_wire_protect_ch2 wpc_ch2_checker chk (.ref_clk, .rst_b, .regAddr, .regWrStrobe,
	.regWrData, .regRdStrobe, .regRdData, .regHit, .channelRequest, .channelEnable,
	.wireTrip, .delayTrip, .coolActive, .latchedOff);
`default_nettype wire

// >>> wpc_host_model.sv
/* Host model: register strobes, load current and on request.
   Assumes the block samples all of them on rising ref_clk. */
`timescale 1ns/100ps
`default_nettype none
module wpc_host_model (
	input  wire logic        ref_clk,
	input  wire logic [15:0] regRdData,
	output var  logic [7:0]  regAddr,
	output var  logic        regWrStrobe,
	output var  logic [15:0] regWrData,
	output var  logic        regRdStrobe,
	output var  logic [15:0] senseCurrent,
	output var  logic        channelRequest
);
	// Idle bus; current in 10 mA at a 700 ohm sense resistor
	initial begin
		regAddr = 8'h00;
		regWrStrobe = 1'b0;
		regWrData = 16'h0000;
		regRdStrobe = 1'b0;
		senseCurrent = 16'h0000;
		channelRequest = 1'b0;
	end
	// One write; data inverted once released
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge ref_clk);
		regWrStrobe <= 1'b0;
		regWrData <= ~d;
	endtask : wr
	// One read; data taken after the taking edge
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge ref_clk);
		regRdStrobe <= 1'b0;
		#1 d = regRdData;
	endtask : rd
endmodule : wpc_host_model
`default_nettype wire

// >>> wpc_pkg.sv
/*
 * Constants for the channel 2 wire protection configuration register and its engine:
 * register offset and field layout, code tables and timing figures.
 * Assumes a 100 MHz clock and a current sample in units of 10 mA.
 */
// Notes on behaviour
// - Cool-down code 0 latches off; codes 1-3 retry after 0.8, 2.0, 4.0 s.
// - Channel turns off after current stays above threshold for 0.2/0.4/1.0/2.0 ms.
// - Delayed-off threshold codes 0-3 give 19.55, 17.6, 16.05, 13.3 A.
// - Trip energy code selects one of sixteen levels, 8.8 to 350 A2s.
// - Nominal current codes 0-7 give 4.0 to 15.0 A.
package wpc_pkg;
	localparam logic [7:0]  CFG_OFFSET      = 8'h1C;
	localparam logic [15:0] CFG_RESET       = 16'h0000;
	localparam logic [15:0] CFG_WR_MASK     = 16'hC7FF;  // Bits 13-11 reserved, read zero
	localparam int          COOL_LSB        = 14;
	localparam int          TMR_LSB         = 9;
	localparam int          THR_LSB         = 7;
	localparam int          TRIP_LSB        = 3;
	localparam int          NOM_LSB         = 0;

	// Timing base: one protection tick every microsecond
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          TICK_PERIOD_NS  = 1000;
	localparam int          TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int          TICKS_PER_MS    = 1000;

	// Delayed-off timer, in microseconds
	localparam logic [11:0] DLY_US [4]      = '{12'h0C8, 12'h190, 12'h3E8, 12'h7D0};
	// Cool-down, in milliseconds; code 0 is latch-off
	localparam logic [11:0] COOL_MS [4]     = '{12'h000, 12'h320, 12'h7D0, 12'hFA0};
	// Delayed-off current threshold, in 10 mA
	localparam logic [15:0] THR_CA [4]      = '{16'h07A3, 16'h06E0, 16'h0645, 16'h0532};
	// Nominal current, in 10 mA
	localparam logic [15:0] NOM_CA [8]      = '{16'h0190, 16'h01F4, 16'h023A, 16'h028A,
	                                            16'h02EE, 16'h0384, 16'h04B0, 16'h05DC};
	// Trip energy, in 0.1 A2s
	localparam logic [11:0] TRIP_DA [16]    = '{12'h058, 12'h083, 12'h107, 12'h18A,
	                                            12'h20D, 12'h290, 12'h314, 12'h397,
	                                            12'h446, 12'h4F5, 12'h5A4, 12'h67F,
	                                            12'h785, 12'h88C, 12'hA41, 12'hDAC};
	// One 0.1 A2s in accumulator units (1e-4 A2 times 1 us)
	localparam logic [47:0] TRIP_SCALE      = 48'h0000_3B9A_CA00;

	typedef enum logic [1:0] {
		WPC_OFF     = 2'b00,
		WPC_ON      = 2'b01,
		WPC_COOL    = 2'b10,
		WPC_LATCHED = 2'b11
	} wpc_state_e;
endpackage : wpc_pkg

// >>> wpc_wire_protect_ch2.sv
/*
 * Channel 2 wire protection: configuration register at its device offset, the
 * current-squared integrator, the delayed turn-off timer and the cool-down sequencer.
 * The engine reads the stored fields directly, so a rewritten code applies at once.
 * Accumulated energy is held through a cool-down and cleared as the wait ends,
 * so a retry starts from a cooled wire instead of tripping again at once.
 * Trip flags record the cause of the last shutdown and clear when the host
 * switches the channel on again from off.
 * A latched channel stays off until the host drops its request.
 * Assumes the serial interface delivers decoded register strobes on ref_clk and
 * that the current sample comes from logic on the same clock, in 10 mA steps,
 * already scaled by the host for the fitted sense resistor.
 */
`timescale 1ns/100ps
`default_nettype none
module wpc_wire_protect_ch2
	import wpc_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrStrobe,
	input  wire logic [15:0] regWrData,
	input  wire logic        regRdStrobe,
	output var  logic [15:0] regRdData,
	output logic             regHit,
	input  wire logic [15:0] senseCurrent,
	input  wire logic        channelRequest,
	output var  logic        channelEnable,
	output var  logic        wireTrip,
	output var  logic        delayTrip,
	output var  logic        coolActive,
	output var  logic        latchedOff
);
	logic [15:0] cfg_reg;
	logic [15:0] rdData_reg;
	wpc_state_e  state_reg;
	wpc_state_e  state_next;
	logic [31:0] tickCnt_reg;
	logic [47:0] energy_reg;
	logic [47:0] energy_next;
	logic [11:0] dlyCnt_reg;
	logic [31:0] coolCnt_reg;
	logic        wireTrip_reg;
	logic        delayTrip_reg;

	// Field extraction from the stored word
	wire logic [1:0]  coolCode   = cfg_reg[COOL_LSB +: 2];
	wire logic [1:0]  tmrCode    = cfg_reg[TMR_LSB +: 2];
	wire logic [1:0]  thrCode    = cfg_reg[THR_LSB +: 2];
	wire logic [3:0]  tripCode   = cfg_reg[TRIP_LSB +: 4];
	wire logic [2:0]  nomCode    = cfg_reg[NOM_LSB +: 3];

	// Address decode and read selection; reserved bits read as zero
	wire logic        cfgSel     = (regAddr == CFG_OFFSET);
	wire logic [15:0] rdMux      = cfgSel ? (cfg_reg & CFG_WR_MASK) : 16'h0000;
	assign regHit = cfgSel;

	// Current and energy limits selected by the codes
	wire logic [15:0] nomCur     = NOM_CA[nomCode];
	wire logic [15:0] thrCur     = THR_CA[thrCode];
	wire logic [47:0] tripLevel  = 48'(TRIP_DA[tripCode]) * TRIP_SCALE;

	// Time limits selected by the codes, in ticks
	wire logic [11:0] dlyLimit   = DLY_US[tmrCode];
	wire logic [31:0] coolLimit  = 32'(COOL_MS[coolCode]) * 32'(TICKS_PER_MS);

	// One tick per microsecond paces all protection timing
	wire logic        tick       = (tickCnt_reg == 32'(TICK_LEN - 1));

	// Squared current terms; both fit 32 bits for a 16-bit sample
	wire logic [31:0] curSq      = 32'(senseCurrent) * 32'(senseCurrent);
	wire logic [31:0] nomSq      = 32'(nomCur) * 32'(nomCur);

	// Shutdown causes, qualified by the channel being on
	wire logic        isOn       = (state_reg == WPC_ON);
	wire logic        overThr    = (senseCurrent > thrCur);
	wire logic        dlyExpire  = isOn && tick && overThr && (dlyCnt_reg + 12'h001 >= dlyLimit);
	wire logic        energyOver = isOn && (energy_next > tripLevel);
	wire logic        shutdown   = dlyExpire || energyOver;
	wire logic        coolDone   = tick && (coolCnt_reg + 32'h0000_0001 >= coolLimit);

	// Integrator: squared excess adds, a margin below nominal drains toward zero
	always_comb begin
		energy_next = energy_reg;
		if (state_reg == WPC_COOL) begin
			if (coolDone) begin
				energy_next = 48'h0000_0000_0000;
			end
		end else if (state_reg != WPC_ON) begin
			energy_next = 48'h0000_0000_0000;
		end else if (tick) begin
			if (curSq >= nomSq) begin
				energy_next = energy_reg + 48'(curSq - nomSq);
			end else if (energy_reg > 48'(nomSq - curSq)) begin
				energy_next = energy_reg - 48'(nomSq - curSq);
			end else begin
				energy_next = 48'h0000_0000_0000;
			end
		end
	end

	// Channel sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			WPC_OFF: begin
				if (channelRequest) begin
					state_next = WPC_ON;
				end
			end
			WPC_ON: begin
				if (shutdown) begin
					state_next = (coolCode == 2'b00) ? WPC_LATCHED : WPC_COOL;
				end else if (!channelRequest) begin
					state_next = WPC_OFF;
				end
			end
			WPC_COOL: begin
				if (!channelRequest) begin
					state_next = WPC_OFF;
				end else if (coolDone) begin
					state_next = WPC_ON;
				end
			end
			WPC_LATCHED: begin
				if (!channelRequest) begin
					state_next = WPC_OFF;
				end
			end
			default: begin
				state_next = WPC_OFF;
			end
		endcase
	end

	// Configuration register; reserved bits never store
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_reg <= CFG_RESET;
		end else if (regWrStrobe && cfgSel) begin
			cfg_reg <= regWrData & CFG_WR_MASK;
		end
	end

	// Read data captured on the read strobe
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_reg <= 16'h0000;
		end else if (regRdStrobe) begin
			rdData_reg <= rdMux;
		end
	end

	// Tick prescaler
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tickCnt_reg <= 32'h0000_0000;
		end else begin
			tickCnt_reg <= tick ? 32'h0000_0000 : tickCnt_reg + 32'h0000_0001;
		end
	end

	// State and energy
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg  <= WPC_OFF;
			energy_reg <= 48'h0000_0000_0000;
		end else begin
			state_reg  <= state_next;
			energy_reg <= energy_next;
		end
	end

	// Delayed turn-off timer restarts whenever current falls back
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dlyCnt_reg <= 12'h000;
		end else if (!isOn || !overThr) begin
			dlyCnt_reg <= 12'h000;
		end else if (tick && !dlyExpire) begin
			dlyCnt_reg <= dlyCnt_reg + 12'h001;
		end
	end

	// Cool-down timer runs only while cooling
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			coolCnt_reg <= 32'h0000_0000;
		end else if (state_reg != WPC_COOL) begin
			coolCnt_reg <= 32'h0000_0000;
		end else if (tick) begin
			coolCnt_reg <= coolCnt_reg + 32'h0000_0001;
		end
	end

	// Trip cause flags hold until the channel is switched on again from off
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wireTrip_reg  <= 1'b0;
			delayTrip_reg <= 1'b0;
		end else if (shutdown) begin
			wireTrip_reg  <= energyOver;
			delayTrip_reg <= dlyExpire;
		end else if (state_reg == WPC_OFF && channelRequest) begin
			wireTrip_reg  <= 1'b0;
			delayTrip_reg <= 1'b0;
		end
	end

	// Register bus output
	assign regRdData     = rdData_reg;

	// Channel state and trip cause outputs
	assign channelEnable = isOn;
	assign wireTrip      = wireTrip_reg;
	assign delayTrip     = delayTrip_reg;
	assign coolActive    = (state_reg == WPC_COOL);
	assign latchedOff    = (state_reg == WPC_LATCHED);
endmodule : wpc_wire_protect_ch2
`default_nettype wire

// >>> wpc_wire_protect_ch2_bench.sv
/* Bench: register, delayed-off and energy trip tests.
   Assumes host model and checker files compile first. */
`timescale 1ns/100ps
`default_nettype none
module wpc_wire_protect_ch2_bench;
	import wpc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	wire logic [7:0] a;
	wire logic [15:0] wd, rd, cur;
	wire logic ws, rs, req, hit, en, wt, dt, ca, lo;
	logic [15:0] d;
	int miscompares = 0;
	int checks_done = 0;
	int n;
	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;
	wpc_host_model host (.ref_clk, .regRdData(rd), .regAddr(a), .regWrStrobe(ws),
		.regWrData(wd), .regRdStrobe(rs), .senseCurrent(cur), .channelRequest(req));
	wpc_wire_protect_ch2 #(.TICK_LEN(2)) dut (.ref_clk, .rst_b, .regAddr(a), .regWrStrobe(ws),
		.regWrData(wd), .regRdStrobe(rs), .regRdData(rd), .regHit(hit), .senseCurrent(cur),
		.channelRequest(req), .channelEnable(en), .wireTrip(wt), .delayTrip(dt),
		.coolActive(ca), .latchedOff(lo));
	// Compare helpers
	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp16
	task automatic cmp1(input logic g, input logic e);
		cmp16({15'h0000, g}, {15'h0000, e});
	endtask : cmp1
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	// Reset value, reserved bits, unmapped address
	task automatic testReg;
		host.rd(8'h1C, d);
		cmp16(d, 16'h0000);
		cmp1(hit, 1'b1);
		host.wr(8'h1C, 16'hFFFF);
		host.wr(8'h1D, 16'h0000);
		host.rd(8'h1C, d);
		cmp16(d, 16'hC7FF);
		host.rd(8'h1D, d);
		cmp16(d, 16'h0000);
		cmp1(hit, 1'b0);
		host.wr(8'h1C, 16'h5A5A);
		host.rd(8'h1C, d);
		cmp16(d, 16'h425A);
		$display("testReg done");
	endtask : testReg
	// 14 A over 13.3 A, below 15 A nominal: 200 ticks then latch
	task automatic testDelay;
		host.wr(8'h1C, 16'h0187);
		host.senseCurrent <= 16'd1400;
		host.channelRequest <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 cmp1(en, 1'b1);
		for (n = 0; n < 2000 && lo !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		cmp1(n >= 396 && n <= 402, 1'b1);
		cmp1(dt, 1'b1);
		repeat (4) @(posedge ref_clk);
		#1 cmp1(en, 1'b0);
		@(posedge ref_clk);
		host.channelRequest <= 1'b0;
		$display("testDelay done");
	endtask : testDelay
	// 655 A over 4 A nominal passes 8.8 A2s on tick 21, then cools down
	task automatic testWire;
		host.wr(8'h1C, 16'h4000);
		host.senseCurrent <= 16'hFFFF;
		host.channelRequest <= 1'b1;
		for (n = 0; n < 400 && ca !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		cmp1(n >= 40 && n <= 48, 1'b1);
		cmp1(wt, 1'b1);
		cmp1(dt, 1'b0);
		cmp1(en, 1'b0);
		$display("testWire done");
	endtask : testWire
	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		testReg;
		testDelay;
		testWire;
		results;
	end
	// Watchdog far past the few hundred cycles needed
	initial begin
		#200000;
		miscompares++;
		results;
	end
endmodule : wpc_wire_protect_ch2_bench
`default_nettype wire
